/* File: logic/cbs_sequencer.sv */
// bus cycle sequencer: fetch, memory, i/o, wait and bus float
`timescale 1ns/1ns
module cbs_sequencer
  import cbs_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // core side
  input wire logic i_cyc_start,
  input wire cbs_kind_t i_cyc_kind,
  input wire logic [15:0] i_cyc_addr,
  input wire logic [7:0] i_cyc_wdata,
  input wire logic [1:0] i_cyc_extra,
  input wire logic [7:0] i_vector_page,
  output logic o_cyc_ready,
  output logic o_cyc_done,
  output logic [7:0] o_cyc_rdata,
  output logic [2:0] o_mcycle_num,
  output logic o_mirq_pending,
  output logic o_nmi_pending,
  // pin side
  output logic [15:0] o_addr,
  output logic o_bus_oe_n,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data,
  output logic o_data_oe_n,
  output logic o_mem_request_n,
  output logic o_port_request_n,
  output logic o_read_strobe_n,
  output logic o_store_strobe_n,
  output logic o_first_cycle_n,
  output logic o_refresh_n,
  output logic o_refresh_addr_bit7,
  output logic o_hold_grant_n,
  input wire logic i_wait_n,
  input wire logic i_hold_request_n,
  input wire logic i_maskable_irq_n,
  input wire logic i_unmaskable_irq_n
);

  //--------------------------------------------------------------
  // state
  //--------------------------------------------------------------
  cbs_state_t state_r, state_nxt;
  cbs_kind_t kind_r;
  logic [1:0] extra_r;
  logic [1:0] forced_r;
  logic refresh_on_r;
  logic [7:0] page_r;
  logic [15:0] addr_r;
  logic [7:0] wdata_r;
  logic [7:0] rdata_r;
  logic done_r;
  logic [2:0] mcyc_r;
  logic mirq_r;
  logic nmi_r;
  logic [7:0] refresh_n_addr;
  logic is_fetch;
  logic is_io;
  logic is_write;
  logic last_state;
  logic enter_t3;
  logic wait_zone;

  assign is_fetch = (kind_r == CBS_FETCH) || (kind_r == CBS_INT_ACK);
  assign is_io = (kind_r == CBS_IO_RD) || (kind_r == CBS_IO_WR);
  assign is_write = (kind_r == CBS_MEM_WR) || (kind_r == CBS_IO_WR);
  assign wait_zone = (state_r == ST_TWF) || (state_r == ST_TW);
  // final state of a machine cycle
  assign last_state = (extra_r == 2'h0) &&
    ((state_r == ST_T4) || (state_r == ST_TEX) ||
     ((state_r == ST_T3) && !is_fetch));
  assign enter_t3 = (state_r != ST_T3) && (state_nxt == ST_T3);

  //--------------------------------------------------------------
  // state machine
  //--------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (!i_hold_request_n) begin
          state_nxt = ST_TX;
        end else if (i_cyc_start) begin
          state_nxt = ST_T1;
        end
      end
      ST_T1: state_nxt = ST_T2;
      ST_T2: begin
        if (is_io || kind_r == CBS_INT_ACK) begin
          state_nxt = ST_TWF;
        end else if (!i_wait_n) begin
          state_nxt = ST_TW;
        end else begin
          state_nxt = ST_T3;
        end
      end
      ST_TWF: begin
        if (forced_r != 2'h0) begin
          state_nxt = ST_TWF;
        end else if (!i_wait_n) begin
          state_nxt = ST_TW;
        end else begin
          state_nxt = ST_T3;
        end
      end
      ST_TW: state_nxt = i_wait_n ? ST_T3 : ST_TW;
      ST_T3, ST_T4, ST_TEX: begin
        if (state_r == ST_T3 && is_fetch) begin
          state_nxt = ST_T4;
        end else if (extra_r != 2'h0) begin
          state_nxt = ST_TEX;
        end else if (!i_hold_request_n) begin
          state_nxt = ST_TX;
        end else begin
          state_nxt = ST_IDLE;
        end
      end
      ST_TX: state_nxt = i_hold_request_n ? ST_IDLE : ST_TX;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // request capture and extra/forced state counts
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      kind_r <= CBS_FETCH;
      extra_r <= 2'h0;
      forced_r <= 2'h0;
      page_r <= CBS_DATA_RST;
      wdata_r <= CBS_DATA_RST;
    end else if (state_r == ST_IDLE && state_nxt == ST_T1) begin
      kind_r <= i_cyc_kind;
      extra_r <= (i_cyc_extra > CBS_EXTRA_MAX) ? CBS_EXTRA_MAX
                                               : i_cyc_extra;
      forced_r <= (i_cyc_kind == CBS_INT_ACK) ? CBS_FORCED_INTA
                                              : CBS_FORCED_IO;
      page_r <= i_vector_page;
      wdata_r <= i_cyc_wdata;
    end else begin
      if (state_r == ST_TWF && forced_r != 2'h0) begin
        forced_r <= forced_r - 2'h1;
      end
      if ((state_r == ST_TEX || state_nxt == ST_TEX) &&
          !(state_r == ST_T3 && is_fetch) && extra_r != 2'h0) begin
        extra_r <= extra_r - 2'h1;
      end
    end
  end

  //--------------------------------------------------------------
  // address bus: cycle address, then refresh address
  //--------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      addr_r <= CBS_ADDR_RST;
    end else if (state_r == ST_IDLE && state_nxt == ST_T1) begin
      addr_r <= i_cyc_addr;
    end else if (enter_t3 && is_fetch) begin
      addr_r <= {page_r, refresh_n_addr};
    end
  end

  // refresh flag: from T3 of a fetch to next T1 or float
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      refresh_on_r <= 1'b0;
    end else if (state_nxt == ST_T1 || state_nxt == ST_TX) begin
      refresh_on_r <= 1'b0;
    end else if (enter_t3 && is_fetch) begin
      refresh_on_r <= 1'b1;
    end
  end

  cbs_refresh_counter u_refresh (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_step(state_r == ST_T3 && is_fetch),
    .o_value(refresh_n_addr)
  );

  //--------------------------------------------------------------
  // read data capture and completion
  //--------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_r <= CBS_DATA_RST;
    end else if (enter_t3 && is_fetch) begin
      rdata_r <= i_data;
    end else if (state_r == ST_T3 && !is_fetch && !is_write) begin
      rdata_r <= i_data;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      done_r <= 1'b0;
    end else begin
      done_r <= last_state;
    end
  end

  // machine cycle number inside the instruction
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      mcyc_r <= CBS_MCYC_FIRST;
    end else if (state_r == ST_IDLE && state_nxt == ST_T1) begin
      if (i_cyc_kind == CBS_FETCH || i_cyc_kind == CBS_INT_ACK) begin
        mcyc_r <= CBS_MCYC_FIRST;
      end else if (mcyc_r < CBS_MCYC_MAX) begin
        mcyc_r <= mcyc_r + 3'h1;
      end
    end
  end

  // interrupt requests blocked while floated
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      mirq_r <= 1'b0;
      nmi_r <= 1'b0;
    end else begin
      mirq_r <= !i_maskable_irq_n && state_r != ST_TX;
      nmi_r <= !i_unmaskable_irq_n && state_r != ST_TX;
    end
  end

  //--------------------------------------------------------------
  // pin outputs
  //--------------------------------------------------------------
  always_comb begin
    o_mem_request_n = 1'b1;
    o_port_request_n = 1'b1;
    o_read_strobe_n = 1'b1;
    o_store_strobe_n = 1'b1;
    o_first_cycle_n = 1'b1;
    unique case (state_r)
      ST_T1, ST_T2, ST_TWF, ST_TW: begin
        // strobes frozen in waits
        if (is_fetch) begin
          o_first_cycle_n = 1'b0;
        end
        if (kind_r == CBS_FETCH) begin
          o_mem_request_n = 1'b0;
          o_read_strobe_n = 1'b0;
        end
        if (kind_r == CBS_INT_ACK && wait_zone) begin
          o_port_request_n = 1'b0;
        end
        if (kind_r == CBS_MEM_RD) begin
          o_mem_request_n = 1'b0;
          o_read_strobe_n = 1'b0;
        end
        if (kind_r == CBS_MEM_WR) begin
          o_mem_request_n = 1'b0;
          o_store_strobe_n = (state_r == ST_T1);
        end
        if (is_io && state_r != ST_T1) begin
          o_port_request_n = 1'b0;
          o_read_strobe_n = (kind_r != CBS_IO_RD);
          o_store_strobe_n = (kind_r != CBS_IO_WR);
        end
      end
      ST_T3: begin
        o_mem_request_n = 1'b0;
        if (is_io) begin
          o_mem_request_n = 1'b1;
          o_port_request_n = 1'b0;
        end
        o_read_strobe_n = is_fetch || is_write;
        o_store_strobe_n = !is_write;
      end
      ST_T4: o_mem_request_n = 1'b1;
      ST_IDLE, ST_TEX, ST_TX: begin
        o_mem_request_n = 1'b1;
      end
    endcase
  end

  assign o_addr = addr_r;
  assign o_bus_oe_n = (state_r == ST_TX);
  assign o_data = wdata_r;
  assign o_data_oe_n = !(is_write && (state_r == ST_T1 ||
    state_r == ST_T2 || wait_zone || state_r == ST_T3)) ||
    (state_r == ST_TX);
  assign o_refresh_n = !refresh_on_r || (state_r == ST_TX);
  assign o_refresh_addr_bit7 = refresh_n_addr[7];
  assign o_hold_grant_n = (state_r != ST_TX);
  assign o_cyc_ready = (state_r == ST_IDLE) && i_hold_request_n;
  assign o_cyc_done = done_r;
  assign o_cyc_rdata = rdata_r;
  assign o_mcycle_num = mcyc_r;
  assign o_mirq_pending = mirq_r;
  assign o_nmi_pending = nmi_r;

endmodule // cbs_sequencer

/* File: logic/cbs_pkg.sv */
// shared types and constants of the bus cycle sequencer
package cbs_pkg;

  // kind of machine cycle requested by the core
  typedef enum logic [2:0] {
    CBS_FETCH,
    CBS_MEM_RD,
    CBS_MEM_WR,
    CBS_IO_RD,
    CBS_IO_WR,
    CBS_INT_ACK
  } cbs_kind_t;

  // clock states of one machine cycle, plus idle and float
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_T1,
    ST_T2,
    ST_TWF,
    ST_TW,
    ST_T3,
    ST_T4,
    ST_TEX,
    ST_TX
  } cbs_state_t;

  // extra states beyond the nominal minimum (fetch 4..6, memory 3..5, i/o 4..6, int ack 6..8)
  localparam logic [1:0] CBS_EXTRA_MAX = 2'h2;
  // forced wait states after the second state, minus one
  localparam logic [1:0] CBS_FORCED_IO = 2'h0;
  localparam logic [1:0] CBS_FORCED_INTA = 2'h1;
  // refresh address width and reset value
  localparam int CBS_REFRESH_N_W = 8;
  localparam logic [7:0] CBS_REFRESH_N_RST = 8'h00;
  // machine cycles per instruction: 1..6
  localparam logic [2:0] CBS_MCYC_MAX = 3'h6;
  localparam logic [2:0] CBS_MCYC_FIRST = 3'h1;
  localparam logic [15:0] CBS_ADDR_RST = 16'h0000;
  localparam logic [7:0] CBS_DATA_RST = 8'h00;

endpackage

/* File: logic/cbs_refresh_counter.sv */
// eight-bit refresh address counter
`timescale 1ns/1ns
module cbs_refresh_counter
  import cbs_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_step,
  output logic [CBS_REFRESH_N_W-1:0] o_value
);

  logic [CBS_REFRESH_N_W-1:0] count_r;

  // low seven bits and bit seven wrap together, 00..FF
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      count_r <= CBS_REFRESH_N_RST;
    end else if (i_step) begin
      count_r <= count_r + 8'h01;
    end
  end

  assign o_value = count_r;

endmodule // cbs_refresh_counter

/* File: testbench/cbs_sequencer_checker.sv */
// pin assertions of the bus cycle sequencer
`timescale 1ns/1ns
module cbs_sequencer_checker (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_hold_request_n,
  input wire logic i_maskable_irq_n,
  input wire logic o_cyc_done,
  input wire logic o_mirq_pending,
  input wire logic o_nmi_pending,
  input wire logic o_bus_oe_n,
  input wire logic o_data_oe_n,
  input wire logic o_mem_request_n,
  input wire logic o_port_request_n,
  input wire logic o_read_strobe_n,
  input wire logic o_store_strobe_n,
  input wire logic o_first_cycle_n,
  input wire logic o_refresh_n,
  input wire logic o_hold_grant_n
);
  // ----
  // strobe and float relations
  // ----
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  property p_grant; !o_hold_grant_n |-> o_bus_oe_n && o_refresh_n; endproperty
  a_grant: assert property (p_grant)
    else $error("grant without float");
  property p_hold; o_cyc_done && !i_hold_request_n |=> !o_hold_grant_n;
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold not granted");
  property p_leave; !o_hold_grant_n && i_hold_request_n |=> o_hold_grant_n;
  endproperty
  a_leave: assert property (p_leave)
    else $error("float not left");
  property p_irq; !o_hold_grant_n |=> !o_mirq_pending && !o_nmi_pending;
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq taken in float");
  property p_mirq; o_hold_grant_n && !i_maskable_irq_n |=> o_mirq_pending;
  endproperty
  a_mirq: assert property (p_mirq)
    else $error("irq request lost");
  property p_store; !o_store_strobe_n |->
    !o_data_oe_n && (o_mem_request_n ^ o_port_request_n); endproperty
  a_store: assert property (p_store)
    else $error("store without data");
  property p_refresh_n; $fell(o_refresh_n) |->
    o_read_strobe_n && o_first_cycle_n; endproperty
  a_refresh_n: assert property (p_refresh_n)
    else $error("refresh with read");
  property p_port; !o_port_request_n |-> o_mem_request_n; endproperty
  a_port: assert property (p_port)
    else $error("both requests low");
  property p_m1; $rose(o_first_cycle_n) && o_port_request_n |->
    !o_refresh_n; endproperty
  a_m1: assert property (p_m1)
    else $error("no refresh after fetch");
  property p_fetch; !o_first_cycle_n && !o_mem_request_n |->
    !o_read_strobe_n; endproperty
  a_fetch: assert property (p_fetch)
    else $error("fetch without read");
  property p_read; !o_read_strobe_n |-> o_store_strobe_n && o_data_oe_n;
  endproperty
  a_read: assert property (p_read)
    else $error("read while driving");
  c_float: cover property (!o_hold_grant_n);
  c_out: cover property (!o_store_strobe_n && !o_port_request_n);
  c_refresh_n: cover property ($fell(o_refresh_n));
endmodule // cbs_sequencer_checker

bind cbs_sequencer cbs_sequencer_checker u_cbs_sequencer_checker (
  .i_clk_sys, .i_nrst, .i_hold_request_n, .i_maskable_irq_n, .o_cyc_done,
  .o_mirq_pending, .o_nmi_pending, .o_bus_oe_n, .o_data_oe_n,
  .o_mem_request_n, .o_port_request_n, .o_read_strobe_n,
  .o_store_strobe_n, .o_first_cycle_n, .o_refresh_n, .o_hold_grant_n);

/* File: testbench/cbs_bus_partner.sv */
// memory and port model with wait insertion
`timescale 1ns/1ns
module cbs_bus_partner (
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic [1:0] i_wait_len,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_data_oe_n,
  input wire logic i_mem_request_n,
  input wire logic i_port_request_n,
  input wire logic i_read_strobe_n,
  input wire logic i_store_strobe_n,
  output logic [7:0] o_data,
  output logic o_wait_n,
  output logic [7:0] o_wr_byte
);
  logic [2:0] run_r;
  logic [7:0] junk_r;
  logic req;
  assign req = !i_mem_request_n || !i_port_request_n;
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      run_r <= 3'h0;
      junk_r <= 8'hC3;
    end else begin
      run_r <= req ? run_r + {2'h0, run_r != 3'h7} : 3'h0;
      junk_r <= junk_r + 8'h3B;
      if (!i_store_strobe_n && !i_data_oe_n) o_wr_byte <= i_wdata;
    end
  end
  // slow answer: hold wait low while request is young
  assign o_wait_n = !(req && run_r < {1'b0, i_wait_len});
  // released bus shows a changing pattern
  assign o_data = ((!i_read_strobe_n || !i_port_request_n) && i_data_oe_n)
    ? i_addr[7:0] ^ i_addr[15:8] ^ 8'h5A : junk_r;
endmodule // cbs_bus_partner

/* File: testbench/test_cbs_sequencer.sv */
// self-checking bench of the bus cycle sequencer
`timescale 1ns/1ns
module test_cbs_sequencer;
  import cbs_pkg::*;
  `define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
    $display("FAIL %0t mismatch", $time); end end
  logic i_clk_sys = 1'b0, i_nrst = 1'b0, i_cyc_start = 1'b0, i_wait_n;
  logic i_hold_request_n = 1'b1, i_maskable_irq_n = 1'b1;
  logic i_unmaskable_irq_n = 1'b1, prev_rf = 1'b1;
  cbs_kind_t i_cyc_kind = CBS_FETCH;
  logic [15:0] i_cyc_addr = 16'h0000, o_addr;
  logic [7:0] i_cyc_wdata = 8'h00, i_vector_page = 8'h00, i_data, o_data;
  logic [7:0] o_cyc_rdata, wr_byte, rc = 8'h00;
  logic [1:0] i_cyc_extra = 2'h0, wait_len = 2'h0;
  logic o_cyc_ready, o_cyc_done, o_bus_oe_n, o_data_oe_n, o_mem_request_n;
  logic o_port_request_n, o_read_strobe_n, o_store_strobe_n;
  logic o_first_cycle_n, o_refresh_n, o_refresh_addr_bit7, o_hold_grant_n;
  logic [11:0] note;
  logic [11:0] notes[$];
  logic [2:0] o_mcycle_num, mc = CBS_MCYC_FIRST;
  time due[$];
  int fails = 0, checked = 0, cyc = 0;
  int base[6] = '{4, 3, 3, 4, 4, 6};
  integer seed = 32'hDE405B6C;
  cbs_sequencer u_cbs_sequencer (.i_clk_sys, .i_nrst, .i_cyc_start,
    .i_cyc_kind, .i_cyc_addr, .i_cyc_wdata, .i_cyc_extra, .i_vector_page,
    .o_cyc_ready, .o_cyc_done, .o_cyc_rdata, .o_mcycle_num,
    .o_mirq_pending(), .o_nmi_pending(), .o_addr, .o_bus_oe_n, .i_data,
    .o_data, .o_data_oe_n, .o_mem_request_n, .o_port_request_n,
    .o_read_strobe_n, .o_store_strobe_n, .o_first_cycle_n, .o_refresh_n,
    .o_refresh_addr_bit7, .o_hold_grant_n, .i_wait_n, .i_hold_request_n,
    .i_maskable_irq_n, .i_unmaskable_irq_n);
  cbs_bus_partner u_cbs_bus_partner (.i_clk_sys, .i_nrst,
    .i_wait_len(wait_len), .i_addr(o_addr), .i_wdata(o_data),
    .i_data_oe_n(o_data_oe_n), .i_mem_request_n(o_mem_request_n),
    .i_port_request_n(o_port_request_n), .i_read_strobe_n(o_read_strobe_n),
    .i_store_strobe_n(o_store_strobe_n), .o_data(i_data),
    .o_wait_n(i_wait_n), .o_wr_byte(wr_byte));
  // ----
  // clock, timeout, verdict
  // ----
  always #10 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      test_done();
    end
  end
  task automatic test_done();
    if (fails == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // one machine cycle, optionally refused by a float first
  task automatic op(input int k, input int h);
    int n;
    do @(negedge i_clk_sys); while (o_cyc_ready !== 1'b1);
    i_cyc_kind = cbs_kind_t'(k);
    i_cyc_addr = $random(seed);
    i_cyc_wdata = $random(seed);
    i_cyc_extra = $random(seed);
    wait_len = $random(seed);
    i_vector_page = $random(seed);
    i_cyc_start = 1'b1;
    repeat (h) begin
      i_hold_request_n = 1'b0; // short floats, no refresh needed
      @(negedge i_clk_sys);
    end
    i_hold_request_n = 1'b1;
    #1;
    while (o_cyc_ready !== 1'b1) @(negedge i_clk_sys);
    @(posedge i_clk_sys);
    n = base[k] + (i_cyc_extra > 2 ? 2 : i_cyc_extra);
    n = n + (wait_len > 0 ? wait_len - 1 : 0);
    due.push_back($time + n * 20 + 10);
    mc = (k == 0 || k == 5) ? CBS_MCYC_FIRST :
      (mc < CBS_MCYC_MAX) ? mc + 3'h1 : mc;
    notes.push_back((k == 2 || k == 4) ? {mc, 1'b1, i_cyc_wdata} :
      {mc, 1'b0, i_cyc_addr[7:0] ^ i_cyc_addr[15:8] ^ 8'h5A});
    @(negedge i_clk_sys);
    i_cyc_start = 1'b0;
  endtask
  // ----
  // result watcher
  // ----
  always @(negedge i_clk_sys) begin
    i_maskable_irq_n <= $random(seed);
    i_unmaskable_irq_n <= $random(seed);
    if (o_cyc_done === 1'b1) begin
      `CHK(due.size() != 0, 1'b1)
      if (due.size() != 0) begin
        `CHK($time, due.pop_front())
        note = notes.pop_front();
        `CHK(note[8] ? wr_byte : o_cyc_rdata, note[7:0])
        `CHK(o_mcycle_num, note[11:9])
      end
    end
    if (o_refresh_n === 1'b0 && prev_rf) begin
      `CHK({o_addr, o_refresh_addr_bit7}, {i_vector_page, rc, rc[7]})
      rc++;
    end
    prev_rf = o_refresh_n;
  end
  initial begin
    repeat (10) @(negedge i_clk_sys);
    i_nrst = 1'b1;
    for (int i = 0; i < 6; i++) op(i, 0);
    repeat (900) op($unsigned($random(seed)) % 6,
      ($random(seed) & 7) == 0 ? 3 : 0);
    repeat (20) @(negedge i_clk_sys);
    `CHK(due.size(), 0)
    test_done();
  end
endmodule // test_cbs_sequencer
